// *** logic/pgp_port_top.sv ***
// Top of the general-purpose port block: Wishbone slave, registers,
// the byte-wide port with alternate functions, and the single-bit port.
// Assumes all pin inputs are already synchronous to clock_in.
`timescale 1ns/1ps
module pgp_port_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Byte-wide port pins
  input wire logic [7:0] port10_pin_in,
  output logic [7:0] port10_pin_out,
  output logic [7:0] port10_pin_oe_n_out,
  output logic [7:0] port10_pullup_en_out,
  // Alternate sources for the byte-wide port
  input wire logic [7:0] realtime_out_in,
  input wire logic [7:0] ext_addr_line_in,
  // Single-bit port pin
  input wire logic port12_pin_in,
  output logic port12_pin_out,
  output logic port12_pin_oe_n_out,
  output logic bus_wait_out
);

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic bus_req;
  logic wr_cycle;
  logic [7:0] wbyte;
  logic hit_port10_latch;
  logic hit_port10_dir;
  logic hit_port10_pullup;
  logic hit_port10_od;
  logic hit_port10_alt_en;
  logic hit_port10_alt_src;
  logic hit_p12_dir;
  logic hit_p12_func;
  logic hit_p12_latch;

  // Write lands on the edge where ack is seen high, as the master expects
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_cycle = bus_req & wb_we_i & ack_ff & wb_sel_i[pgp_pkg::BYTE_LANE0];
  assign wbyte = wb_dat_i[7:0];
  assign hit_port10_latch = (wb_adr_i == pgp_pkg::ADDR_PORT10_LATCH);
  assign hit_port10_dir = (wb_adr_i == pgp_pkg::ADDR_PORT10_DIR);
  assign hit_port10_pullup = (wb_adr_i == pgp_pkg::ADDR_PORT10_PULLUP);
  assign hit_port10_od = (wb_adr_i == pgp_pkg::ADDR_PORT10_OPENDRAIN);
  assign hit_port10_alt_en = (wb_adr_i == pgp_pkg::ADDR_PORT10_ALT_EN);
  assign hit_port10_alt_src = (wb_adr_i == pgp_pkg::ADDR_PORT10_ALT_SRC);
  assign hit_p12_dir = (wb_adr_i == pgp_pkg::ADDR_P12_DIR);
  assign hit_p12_func = (wb_adr_i == pgp_pkg::ADDR_P12_FUNC);
  assign hit_p12_latch = (wb_adr_i == pgp_pkg::ADDR_P12_LATCH);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] port10_output_latch;
  logic [7:0] port10_dir;
  logic [7:0] port10_pullup;
  logic [7:0] port10_od;
  logic [7:0] port10_alt_en;
  logic [7:0] port10_alt_src;
  logic [7:0] p12_dir;
  logic [7:0] p12_func;
  logic [7:0] p12_latch;

  // Output latch; written even in input mode, pins untouched then
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_PORT10_LATCH), .WR_MASK(pgp_pkg::MASK_ALL)) u_port10_latch (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_port10_latch), // [RULE_04] [RULE_09]
    .wr_data_in(wbyte),
    .value_out(port10_output_latch)
  );

  // Per-bit direction, 1 is input
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_PORT10_DIR), .WR_MASK(pgp_pkg::MASK_ALL)) u_port10_dir (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_port10_dir), // [RULE_01]
    .wr_data_in(wbyte),
    .value_out(port10_dir)
  );

  // Per-bit pull-up enable
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_PORT10_PULLUP), .WR_MASK(pgp_pkg::MASK_ALL)) u_port10_pullup (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_port10_pullup), // [RULE_02]
    .wr_data_in(wbyte),
    .value_out(port10_pullup)
  );

  // Per-bit open-drain select
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_PORT10_OPENDRAIN), .WR_MASK(pgp_pkg::MASK_ALL)) u_port10_od (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_port10_od), // [RULE_03]
    .wr_data_in(wbyte),
    .value_out(port10_od)
  );

  // Per-bit alternate function enable
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_PORT10_ALT_EN), .WR_MASK(pgp_pkg::MASK_ALL)) u_port10_alt_en (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_port10_alt_en), // [RULE_05]
    .wr_data_in(wbyte),
    .value_out(port10_alt_en)
  );

  // Alternate source: 0 real-time output, 1 address line
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_PORT10_ALT_SRC), .WR_MASK(pgp_pkg::MASK_BIT0)) u_port10_alt_src (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_port10_alt_src), // [RULE_05]
    .wr_data_in(wbyte),
    .value_out(port10_alt_src)
  );

  // Single-bit direction; upper bits are fixed at zero
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_P12_DIR), .WR_MASK(pgp_pkg::MASK_BIT0)) u_p12_dir ( // [RULE_06]
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_p12_dir),
    .wr_data_in(wbyte),
    .value_out(p12_dir)
  );

  // Single-bit function select, byte or bit access alike
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_P12_FUNC), .WR_MASK(pgp_pkg::MASK_BIT0)) u_p12_func ( // [RULE_07] [RULE_08]
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_p12_func),
    .wr_data_in(wbyte),
    .value_out(p12_func)
  );

  // Single-bit output latch
  pgp_byte_reg #(.RESET_VAL(pgp_pkg::RST_P12_LATCH), .WR_MASK(pgp_pkg::MASK_BIT0)) u_p12_latch (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_cycle & hit_p12_latch),
    .wr_data_in(wbyte),
    .value_out(p12_latch)
  );

  // ************************************************************
  // Byte-wide port pin logic
  // ************************************************************
  logic [7:0] port10_alt_data;
  logic [7:0] port10_data;
  logic [7:0] port10_out_mode;
  logic [7:0] port10_readback;

  // Alternate function forces the pin to output and overrides the latch
  assign port10_alt_data = port10_alt_src[pgp_pkg::BIT0] ? ext_addr_line_in : realtime_out_in; // [RULE_05]
  assign port10_data = (port10_alt_en & port10_alt_data) | (~port10_alt_en & port10_output_latch); // [RULE_04]
  assign port10_out_mode = ~port10_dir | port10_alt_en; // [RULE_01]
  // Input bits read the pin, output bits read the latch
  assign port10_readback = (port10_dir & port10_pin_in) | (~port10_dir & port10_output_latch); // [RULE_09]

  // One output stage per pin
  genvar gi;
  generate
    for (gi = 0; gi < pgp_pkg::PORT_W; gi++) begin : g_port10_pad
      pgp_pad_cell u_pad (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .out_mode_in(port10_out_mode[gi]),
        .open_drain_in(port10_od[gi]), // [RULE_03]
        .data_in(port10_data[gi]),
        .pin_out(port10_pin_out[gi]),
        .pin_oe_n_out(port10_pin_oe_n_out[gi])
      );
    end
  endgenerate

  // Pull-up enables come straight from their register flops
  assign port10_pullup_en_out = port10_pullup; // [RULE_02]

  // ************************************************************
  // Single-bit port pin logic
  // ************************************************************
  logic p12_is_wait;
  logic p12_out_mode;
  logic p12_readback;
  logic wait_ff;

  // In wait mode the pin is only an input, whatever the direction bit says
  assign p12_is_wait = p12_func[pgp_pkg::BIT0]; // [RULE_07]
  assign p12_out_mode = ~p12_dir[pgp_pkg::BIT0] & ~p12_is_wait; // [RULE_06]
  assign p12_readback = p12_dir[pgp_pkg::BIT0] ? port12_pin_in : p12_latch[pgp_pkg::BIT0];

  pgp_pad_cell u_p12_pad (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .out_mode_in(p12_out_mode),
    .open_drain_in(1'b0),
    .data_in(p12_latch[pgp_pkg::BIT0]),
    .pin_out(port12_pin_out),
    .pin_oe_n_out(port12_pin_oe_n_out)
  );

  // Wait request passes to the bus only while the pin is in wait mode
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= p12_is_wait & port12_pin_in; // [RULE_07]
    end
  end
  assign bus_wait_out = wait_ff;

  // ************************************************************
  // Read mux and acknowledge
  // ************************************************************
  logic [7:0] rd_byte;
  logic [31:0] nxt_rdata;
  logic nxt_ack;

  // Unmapped addresses still ack, with zero data, so the bus never hangs
  assign rd_byte = hit_port10_latch ? port10_readback :
                   hit_port10_dir ? port10_dir :
                   hit_port10_pullup ? port10_pullup :
                   hit_port10_od ? port10_od :
                   hit_port10_alt_en ? port10_alt_en :
                   hit_port10_alt_src ? port10_alt_src :
                   hit_p12_dir ? p12_dir : // [RULE_06]
                   hit_p12_func ? p12_func : // [RULE_08]
                   hit_p12_latch ? {p12_latch[7:1], p12_readback} : 8'h00;
  assign nxt_rdata = {pgp_pkg::UPPER_ZERO, rd_byte};
  assign nxt_ack = bus_req & ~ack_ff;

  // One wait state, then ack for exactly one cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_ack_single: assert property (@(posedge clock_in) disable iff (rst_in)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

  a_ack_latency: assert property (@(posedge clock_in) disable iff (rst_in)
    (bus_req && !wb_ack_o) |=> wb_ack_o) else $error("ack not one cycle after request");

  a_latch_write: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_04]
    (wr_cycle && hit_port10_latch) |=> (port10_output_latch == $past(wbyte))) else $error("output latch not written");

  // Bit 4 is an output without open drain in the bench until open drain is set on the upper nibble, so this really fires
  a_pin_follow: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_04]
    (!port10_dir[4] && !port10_alt_en[4] && !port10_od[4]) |=>
    (!port10_pin_oe_n_out[4] && port10_pin_out[4] == $past(port10_output_latch[4])))
    else $error("output pin does not follow latch");

  a_od_release: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_03]
    (port10_od[6] && port10_data[6]) |=> port10_pin_oe_n_out[6]) else $error("open drain drove a high level");

  a_input_float: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_01]
    (port10_dir[2] && !port10_alt_en[2]) |=> port10_pin_oe_n_out[2]) else $error("input pin is driven");

  a_input_untouched: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_09]
    (wr_cycle && hit_port10_latch && port10_dir[0] && !port10_alt_en[0]) |=> port10_pin_oe_n_out[0])
    else $error("latch write drove an input pin");

  a_pullup_write: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_02]
    (wr_cycle && hit_port10_pullup) |=> (port10_pullup_en_out == $past(wbyte))) else $error("pull-up enable not updated");

  a_alt_addr: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_05]
    (port10_alt_en[3] && port10_alt_src[0]) |=> (port10_pin_out[3] == $past(ext_addr_line_in[3])))
    else $error("address line not on pin");

  a_dir12_upper: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_06]
    (wb_ack_o && hit_p12_dir && !wb_we_i) |-> (wb_dat_o[31:1] == 31'h00000000)) else $error("direction upper bits not zero");

  a_wait_pass: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_07]
    p12_is_wait |=> (bus_wait_out == $past(port12_pin_in) && port12_pin_oe_n_out)) else $error("wait input mishandled");

  a_func_write: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_08]
    (wr_cycle && hit_p12_func) |=> (p12_func == {7'h00, $past(wbyte[0])})) else $error("function register not written");

  a_input_read: assert property (@(posedge clock_in) disable iff (rst_in) // [RULE_09]
    (bus_req && !wb_ack_o && hit_port10_latch && port10_dir == 8'hff) |=> (wb_dat_o[7:0] == $past(port10_pin_in)))
    else $error("input pin level not read back");

endmodule // pgp_port_top

// *** logic/pgp_pkg.sv ***
// Constants for the general-purpose port block: the byte-wide port
// and the single-bit port, reached over a classic Wishbone slave.
// Assumes a 32-bit Wishbone master with byte addresses and lane 0 used.
// Summary of operation
// [RULE_01] Eight port pins, each set to input or output on its own.
// [RULE_02] Each of the eight pins has its own pull-up enable bit.
// [RULE_03] Each eight-pin output is push-pull or open-drain pulling low only.
// [RULE_04] Output pins follow the output latch; latch bits reset to zero.
// [RULE_05] Each pin also carries a real-time output bit and address lines 5 to 12.
// [RULE_06] Single-bit direction register: bit 0 only, resets to 01h, 0 selects output.
// [RULE_07] Single-bit function register resets to zero; 1 makes the pin bus wait input.
// [RULE_08] The function register is read and written as a bit or a byte.
// [RULE_09] Input pins read back the pin level; writes only update the latch.
package pgp_pkg;

  // ************************************************************
  // Register byte addresses
  // ************************************************************
  localparam logic [31:0] ADDR_PORT10_LATCH = 32'hfffff014;
  localparam logic [31:0] ADDR_P12_DIR = 32'hfffff038;
  localparam logic [31:0] ADDR_P12_FUNC = 32'h0ffff058;
  localparam logic [31:0] ADDR_PORT10_DIR = 32'hfffff100;
  localparam logic [31:0] ADDR_PORT10_PULLUP = 32'hfffff104;
  localparam logic [31:0] ADDR_PORT10_OPENDRAIN = 32'hfffff108;
  localparam logic [31:0] ADDR_PORT10_ALT_EN = 32'hfffff10c;
  localparam logic [31:0] ADDR_PORT10_ALT_SRC = 32'hfffff110;
  localparam logic [31:0] ADDR_P12_LATCH = 32'hfffff114;

  // ************************************************************
  // Reset values and writable-bit masks
  // ************************************************************
  localparam logic [7:0] RST_PORT10_LATCH = 8'h00;
  localparam logic [7:0] RST_PORT10_DIR = 8'hff;
  localparam logic [7:0] RST_PORT10_PULLUP = 8'h00;
  localparam logic [7:0] RST_PORT10_OPENDRAIN = 8'h00;
  localparam logic [7:0] RST_PORT10_ALT_EN = 8'h00;
  localparam logic [7:0] RST_PORT10_ALT_SRC = 8'h00;
  localparam logic [7:0] RST_P12_DIR = 8'h01;
  localparam logic [7:0] RST_P12_FUNC = 8'h00;
  localparam logic [7:0] RST_P12_LATCH = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_BIT0 = 8'h01;

  // ************************************************************
  // Field positions and widths
  // ************************************************************
  localparam int BIT0 = 0;
  localparam int PORT_W = 8;
  localparam int BYTE_LANE0 = 0;
  localparam logic [23:0] UPPER_ZERO = 24'h000000;

endpackage : pgp_pkg

// *** logic/pgp_byte_reg.sv ***
// One byte-wide software register with a reset value and a writable mask.
// Assumes the caller forms a one-cycle write enable from the bus.
`timescale 1ns/1ps
module pgp_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hff
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Write side
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  // Stored value
  output logic [7:0] value_out
);

  logic [7:0] value_ff;
  logic [7:0] nxt_value;

  // Unimplemented bits keep their reset value, so they read back fixed
  assign nxt_value = wr_en_in ? ((wr_data_in & WR_MASK) | (RESET_VAL & ~WR_MASK)) : value_ff;
  assign value_out = value_ff;

  // Storage
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      value_ff <= RESET_VAL;
    end else begin
      value_ff <= nxt_value;
    end
  end

endmodule // pgp_byte_reg

// *** logic/pgp_pad_cell.sv ***
// Output stage of one port pin: registered level and registered enable.
// Assumes the pad wire is resolved outside; enable is low while driving.
`timescale 1ns/1ps
module pgp_pad_cell (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire logic out_mode_in,
  input wire logic open_drain_in,
  input wire logic data_in,
  // Pad side
  output logic pin_out,
  output logic pin_oe_n_out
);

  logic pin_ff;
  logic oe_n_ff;
  logic nxt_oe_n;

  // Open-drain only drives for a low level; a high is left to the pull-up
  assign nxt_oe_n = ~(out_mode_in & (~open_drain_in | ~data_in));
  assign pin_out = pin_ff;
  assign pin_oe_n_out = oe_n_ff;

  // Registered so the pad sees no decode glitches
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pin_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      pin_ff <= data_in;
      oe_n_ff <= nxt_oe_n;
    end
  end

endmodule // pgp_pad_cell

// *** test/pgp_port_top_tb_top.sv ***
// Self-checking bench for the general-purpose port block, driven over Wishbone.
// Assumes pgp_pkg and the design files are compiled first; no separate partner.
`timescale 1ns/1ps
module pgp_port_top_tb_top;
  // ************************************************************
  // Signals
  // ************************************************************
  logic clock_in, rst_in, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i;
  logic [7:0] port10_pin_in, port10_pin_out, port10_pin_oe_n_out, port10_pullup_en_out;
  logic [7:0] realtime_out_in, ext_addr_line_in;
  logic port12_pin_in, port12_pin_out, port12_pin_oe_n_out, bus_wait_out;
  int err_count = 0;
  int n_tests = 0;
  logic [31:0] reg_adr [9];
  logic [7:0] reg_rst [9];

  pgp_port_top dut (.clock_in(clock_in), .rst_in(rst_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port10_pin_in(port10_pin_in),
    .port10_pin_out(port10_pin_out), .port10_pin_oe_n_out(port10_pin_oe_n_out),
    .port10_pullup_en_out(port10_pullup_en_out), .realtime_out_in(realtime_out_in),
    .ext_addr_line_in(ext_addr_line_in), .port12_pin_in(port12_pin_in),
    .port12_pin_out(port12_pin_out), .port12_pin_oe_n_out(port12_pin_oe_n_out),
    .bus_wait_out(bus_wait_out));

  // Free-running 25 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  // Verdict and end of run
  task automatic end_sim;
    $display("Checks made: %0d, mismatches: %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled high, then released
  // A missing ack is caught by the watchdog, not by a count here
  task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [7:0] dat,
                         input logic [3:0] sel, output logic [31:0] rdat);
    @(posedge clock_in);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    wb_sel_i <= sel;
    do begin
      @(posedge clock_in);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] adr, input logic [7:0] dat);
    logic [31:0] d;
    wb_xfer(1'b1, adr, dat, 4'h1, d);
  endtask

  task automatic rd(input logic [31:0] adr, input logic [7:0] exp);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 8'h00, 4'h1, d);
    chk(d, {24'h000000, exp}, "register read");
  endtask

  // Pad outputs trail the register by one edge
  task automatic settle;
    repeat (2) @(posedge clock_in);
    #1;
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #(40 * 5000);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    end_sim();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rst_in = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 32'h00000000;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'h0;
    port10_pin_in = 8'h00;
    realtime_out_in = 8'h00;
    ext_addr_line_in = 8'h00;
    port12_pin_in = 1'b0;
    reg_adr = '{pgp_pkg::ADDR_PORT10_LATCH, pgp_pkg::ADDR_P12_DIR, pgp_pkg::ADDR_P12_FUNC,
      pgp_pkg::ADDR_PORT10_DIR, pgp_pkg::ADDR_PORT10_PULLUP, pgp_pkg::ADDR_PORT10_OPENDRAIN,
      pgp_pkg::ADDR_PORT10_ALT_EN, pgp_pkg::ADDR_PORT10_ALT_SRC, pgp_pkg::ADDR_P12_LATCH};
    reg_rst = '{8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    // Reset values, all pins released; latch reads pins while all bits are inputs
    settle();
    chk(port10_pin_oe_n_out, 8'hff, "pins released");
    chk(port10_pullup_en_out, 8'h00, "pull-ups off");
    chk(bus_wait_out, 1'b0, "wait idle");
    for (int i = 0; i < 9; i++) rd(reg_adr[i], reg_rst[i]);
    rd(32'hfffff200, 8'h00);
    // Upper nibble output, lower nibble input
    wr(pgp_pkg::ADDR_PORT10_LATCH, 8'ha5);
    wr(pgp_pkg::ADDR_PORT10_DIR, 8'h0f);
    @(posedge clock_in);
    port10_pin_in <= 8'h3c;
    settle();
    chk(port10_pin_oe_n_out, 8'h0f, "direction per bit");
    chk(port10_pin_out[7:4], 4'ha, "latch drives pins");
    rd(pgp_pkg::ADDR_PORT10_LATCH, 8'hac);
    wr(pgp_pkg::ADDR_PORT10_LATCH, 8'h5a);
    settle();
    chk(port10_pin_oe_n_out[3:0], 4'hf, "input pins untouched");
    chk(port10_pin_out[7:4], 4'h5, "new latch value");
    rd(pgp_pkg::ADDR_PORT10_LATCH, 8'h5c);
    // Pull-up per bit and open drain on the upper nibble; latch upper nibble is 0101
    wr(pgp_pkg::ADDR_PORT10_PULLUP, 8'h96);
    wr(pgp_pkg::ADDR_PORT10_OPENDRAIN, 8'hf0);
    settle();
    chk(port10_pullup_en_out, 8'h96, "pull-up per bit");
    chk(port10_pin_oe_n_out, 8'h5f, "open drain pulls low only");
    // Alternate sources: real-time bits, then address lines
    wr(pgp_pkg::ADDR_PORT10_OPENDRAIN, 8'h00);
    wr(pgp_pkg::ADDR_PORT10_ALT_EN, 8'hff);
    @(posedge clock_in);
    realtime_out_in <= 8'h33;
    ext_addr_line_in <= 8'hc5;
    settle();
    chk(port10_pin_out, 8'h33, "real-time output");
    chk(port10_pin_oe_n_out, 8'h00, "alternate drives");
    wr(pgp_pkg::ADDR_PORT10_ALT_SRC, 8'h01);
    settle();
    chk(port10_pin_out, 8'hc5, "address lines");
    // Single-bit port: only bit 0 sticks, 0 selects output
    wr(pgp_pkg::ADDR_P12_DIR, 8'hfe);
    rd(pgp_pkg::ADDR_P12_DIR, 8'h00);
    wr(pgp_pkg::ADDR_P12_LATCH, 8'h01);
    settle();
    chk(port12_pin_oe_n_out, 1'b0, "single pin driven");
    chk(port12_pin_out, 1'b1, "single pin level");
    wr(pgp_pkg::ADDR_P12_DIR, 8'hff);
    rd(pgp_pkg::ADDR_P12_DIR, 8'h01);
    // Function register: byte write keeps bit 0 only, lane-off write ignored
    wr(pgp_pkg::ADDR_P12_FUNC, 8'hff);
    rd(pgp_pkg::ADDR_P12_FUNC, 8'h01);
    begin
      logic [31:0] d;
      wb_xfer(1'b1, pgp_pkg::ADDR_P12_FUNC, 8'h00, 4'h0, d);
    end
    rd(pgp_pkg::ADDR_P12_FUNC, 8'h01);
    @(posedge clock_in);
    port12_pin_in <= 1'b1;
    settle();
    chk(bus_wait_out, 1'b1, "wait input follows pin");
    chk(port12_pin_oe_n_out, 1'b1, "wait pin released");
    wr(pgp_pkg::ADDR_P12_FUNC, 8'h00);
    settle();
    chk(bus_wait_out, 1'b0, "port mode, no wait");
    end_sim();
  end
endmodule // pgp_port_top_tb_top
